// ===== common/i2c_slave_regs.svh
// status codes, bit positions and timing counts of the slave controller
// assumes inclusion by the core files; definitions only
`ifndef I2C_SLAVE_REGS_SVH
`define I2C_SLAVE_REGS_SVH

`define ST_IDLE 8'hF8
`define ST_RX_ADDR 8'h60
`define ST_GC_ADDR 8'h70
`define ST_RX_ACK 8'h80
`define ST_RX_NACK 8'h88
`define ST_GC_ACK 8'h90
`define ST_GC_NACK 8'h98
`define ST_STOP 8'hA0
`define ST_TX_ADDR 8'hA8
`define ST_TX_ACK 8'hB8
`define ST_TX_NACK 8'hC0
`define ST_TX_LAST 8'hC8
`define ADDR_GC_BIT 0
`define BUS_FREE_NS 4700
`define CLK_NS 10
`define BUS_FREE_CYC ((`BUS_FREE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ===== common/i2c_slave_pkg.sv
// types shared by the slave controller files
// assumes nothing beyond the constants header
package i2c_slave_pkg;
	typedef enum logic [6:0] {
		S_IDLE = 7'b0000001,
		S_ADDR = 7'b0000010,
		S_RXBYTE = 7'b0000100,
		S_RXACK = 7'b0001000,
		S_TXBYTE = 7'b0010000,
		S_TXACK = 7'b0100000,
		S_WAIT = 7'b1000000
	} link_state_e;
endpackage : i2c_slave_pkg

// ===== common/i2c_line_if.sv
// sampled bus line events between the edge finder and the controller
// assumes one clock domain, clk_sys
`timescale 1ns/1ns
`default_nettype none
interface i2c_line_if;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;
	logic sdaLevel;
	logic busFree;
	modport src (output sclRise, output sclFall, output startSeen, output stopSeen,
		output sdaLevel, output busFree);
	modport dst (input sclRise, input sclFall, input startSeen, input stopSeen,
		input sdaLevel, input busFree);
endinterface : i2c_line_if
`default_nettype wire

// ===== core/i2c_line_sense.sv
// two-flop synchronisers and edge / start / stop detection of the bus lines
// assumes scl and sda arrive asynchronously to clk_sys
`include "i2c_slave_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module i2c_line_sense (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic sclIn,
	input wire logic sdaIn,
	i2c_line_if.src lines
);
	logic [1:0] sclSync_reg, sclSync_next, sdaSync_reg, sdaSync_next;
	logic sclOld_reg, sclOld_next, sdaOld_reg, sdaOld_next;
	logic busy_reg, busy_next;
	logic [12:0] freeCnt_reg, freeCnt_next;

	always_comb begin
		sclSync_next = {sclSync_reg[0], sclIn};
		sdaSync_next = {sdaSync_reg[0], sdaIn};
		sclOld_next = sclSync_reg[1];
		sdaOld_next = sdaSync_reg[1];
		busy_next = busy_reg;
		freeCnt_next = freeCnt_reg;
		if (lines.startSeen)
			busy_next = 1'b1;
		else if (lines.stopSeen)
			busy_next = 1'b0;
		// bus counts as free after a stop plus the idle time with both lines high
		if (busy_reg || !sclSync_reg[1] || !sdaSync_reg[1])
			freeCnt_next = 13'h0000;
		else if (freeCnt_reg != 13'(`BUS_FREE_CYC))
			freeCnt_next = freeCnt_reg + 13'h0001;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sclSync_reg <= 2'h3;
			sdaSync_reg <= 2'h3;
			sclOld_reg <= 1'b1;
			sdaOld_reg <= 1'b1;
			busy_reg <= 1'b0;
			freeCnt_reg <= 13'h0000;
		end else begin
			sclSync_reg <= sclSync_next;
			sdaSync_reg <= sdaSync_next;
			sclOld_reg <= sclOld_next;
			sdaOld_reg <= sdaOld_next;
			busy_reg <= busy_next;
			freeCnt_reg <= freeCnt_next;
		end
	end

	assign lines.sclRise = sclSync_reg[1] && !sclOld_reg;
	assign lines.sclFall = !sclSync_reg[1] && sclOld_reg;
	assign lines.startSeen = sclSync_reg[1] && sclOld_reg && !sdaSync_reg[1] && sdaOld_reg;
	assign lines.stopSeen = sclSync_reg[1] && sclOld_reg && sdaSync_reg[1] && !sdaOld_reg;
	assign lines.sdaLevel = sdaSync_reg[1];
	assign lines.busFree = freeCnt_reg == 13'(`BUS_FREE_CYC);
endmodule : i2c_line_sense
`default_nettype wire

// ===== core/i2c_slave_ctrl.sv
// slave-side controller: address match, receive, transmit, status codes
// assumes software drives control bits and clears the flag by a one-cycle pulse
`include "i2c_slave_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_ctrl (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// bus pins
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sclOut,
	output logic sclOe,
	output logic sdaOut,
	output logic sdaOe,
	// software control
	input wire logic [7:0] ownSlaveAddr,
	input wire logic ackEnableBit,
	input wire logic startRequestBit,
	input wire logic stopRequestBit,
	input wire logic flagClear,
	input wire logic [7:0] shiftDataIn,
	input wire logic shiftDataWrite,
	// software status
	output logic irqFlag,
	output logic [7:0] statusCode,
	output logic [7:0] shiftData,
	output logic startIssued
);
	i2c_line_if lines ();
	i2c_slave_pkg::link_state_e state_reg, state_next;
	logic [7:0] shift_reg, shift_next;
	logic [2:0] bitCnt_reg, bitCnt_next;
	logic flag_reg, flag_next;
	logic [7:0] status_reg, status_next;
	logic sdaOe_reg, sdaOe_next;
	logic sclOe_reg, sclOe_next;
	logic gcMode_reg, gcMode_next;
	logic txLast_reg, txLast_next;
	logic startPend_reg, startPend_next;
	logic startOut_reg, startOut_next;
	// a whole byte has been shifted in; the fall after a start must not count
	logic byteDone_reg, byteDone_next;
	// the byte before the acknowledge was an address, not data
	logic addrByte_reg, addrByte_next;
	logic addrMatch, gcMatch, acking;

	i2c_line_sense sense (
		.clk_sys(clk_sys),
		.reset(reset),
		.sclIn(sclIn),
		.sdaIn(sdaIn),
		.lines(lines)
	);

	// ack enable is read live, so recognition follows it at once
	assign addrMatch = ackEnableBit && shift_reg[7:1] == ownSlaveAddr[7:1];
	assign gcMatch = ackEnableBit && ownSlaveAddr[`ADDR_GC_BIT] && shift_reg == 8'h00;

	always_comb begin
		state_next = state_reg;
		shift_next = shift_reg;
		bitCnt_next = bitCnt_reg;
		flag_next = flag_reg;
		status_next = status_reg;
		sdaOe_next = sdaOe_reg;
		sclOe_next = sclOe_reg;
		gcMode_next = gcMode_reg;
		txLast_next = txLast_reg;
		startPend_next = startPend_reg;
		startOut_next = 1'b0;
		byteDone_next = byteDone_reg;
		addrByte_next = addrByte_reg;
		acking = 1'b0;
		if (shiftDataWrite && flag_reg)
			shift_next = shiftDataIn;
		// software start request and transmit ack enable are taken only on clearing the flag
		if (flagClear && flag_reg) begin
			flag_next = 1'b0;
			sclOe_next = 1'b0;
			status_next = `ST_IDLE;
			unique case (status_reg)
				`ST_GC_NACK, `ST_STOP, `ST_RX_NACK, `ST_TX_NACK, `ST_TX_LAST: begin
					// not addressed; recognition set by ack enable live
					state_next = i2c_slave_pkg::S_IDLE;
					sdaOe_next = 1'b0;
					startPend_next = startRequestBit;
				end
				`ST_TX_ADDR, `ST_TX_ACK: begin
					// clearing ack enable makes this byte the last one
					txLast_next = !ackEnableBit;
					state_next = i2c_slave_pkg::S_TXBYTE;
					sdaOe_next = !shift_reg[7];
					bitCnt_next = 3'h0;
				end
				default: ;
			endcase
		end else if (lines.stopSeen || (lines.startSeen && state_reg != i2c_slave_pkg::S_IDLE)) begin
			if (state_reg != i2c_slave_pkg::S_IDLE && state_reg != i2c_slave_pkg::S_ADDR
					&& !flag_reg) begin
				flag_next = 1'b1;
				status_next = `ST_STOP;
				sdaOe_next = 1'b0;
				state_next = i2c_slave_pkg::S_WAIT;
			end else if (lines.startSeen) begin
				state_next = i2c_slave_pkg::S_ADDR;
				bitCnt_next = 3'h0;
				byteDone_next = 1'b0;
				sdaOe_next = 1'b0;
			end else begin
				state_next = i2c_slave_pkg::S_IDLE;
				sdaOe_next = 1'b0;
			end
		end else begin
			unique case (state_reg)
				i2c_slave_pkg::S_IDLE: begin
					// bus is still watched while deaf
					if (lines.startSeen) begin
						state_next = i2c_slave_pkg::S_ADDR;
						bitCnt_next = 3'h0;
						byteDone_next = 1'b0;
					end
				end
				i2c_slave_pkg::S_ADDR, i2c_slave_pkg::S_RXBYTE: begin
					if (lines.sclRise) begin
						shift_next = {shift_reg[6:0], lines.sdaLevel};
						bitCnt_next = bitCnt_reg + 3'h1;
						if (bitCnt_reg == 3'h7)
							byteDone_next = 1'b1;
					end
					if (lines.sclFall && byteDone_reg) begin
						byteDone_next = 1'b0;
						addrByte_next = state_reg == i2c_slave_pkg::S_ADDR;
						if (state_reg == i2c_slave_pkg::S_ADDR) begin
							if (addrMatch || gcMatch) begin
								acking = 1'b1;
								gcMode_next = !addrMatch;
							end else
								state_next = i2c_slave_pkg::S_IDLE;
						end else
							acking = ackEnableBit;
						if (acking || state_reg == i2c_slave_pkg::S_RXBYTE) begin
							sdaOe_next = acking;
							state_next = i2c_slave_pkg::S_RXACK;
						end
					end
				end
				i2c_slave_pkg::S_RXACK: begin
					if (lines.sclFall) begin
						sdaOe_next = 1'b0;
						sclOe_next = 1'b1;
						flag_next = 1'b1;
						state_next = i2c_slave_pkg::S_WAIT;
						bitCnt_next = 3'h0;
						if (addrByte_reg && shift_reg[0] && addrMatch && !gcMode_reg) begin
							status_next = `ST_TX_ADDR;
							txLast_next = 1'b0;
						end else if (addrByte_reg)
							status_next = gcMode_reg ? `ST_GC_ADDR : `ST_RX_ADDR;
						else if (gcMode_reg)
							status_next = sdaOe_reg ? `ST_GC_ACK : `ST_GC_NACK;
						else
							status_next = sdaOe_reg ? `ST_RX_ACK : `ST_RX_NACK;
					end
				end
				i2c_slave_pkg::S_WAIT: begin
					// released from the flag: resume the proper phase
					// transmit phases leave straight from the clear
					if (!flag_reg && !sclOe_reg)
						state_next = i2c_slave_pkg::S_RXBYTE;
				end
				i2c_slave_pkg::S_TXBYTE: begin
					if (lines.sclFall) begin
						bitCnt_next = bitCnt_reg + 3'h1;
						shift_next = {shift_reg[6:0], 1'b1};
						sdaOe_next = bitCnt_reg != 3'h7 && !shift_reg[6];
						if (bitCnt_reg == 3'h7)
							state_next = i2c_slave_pkg::S_TXACK;
					end
				end
				i2c_slave_pkg::S_TXACK: begin
					// act at the fall: stretching while the clock is high would cut it short
					if (lines.sclFall) begin
						flag_next = 1'b1;
						sclOe_next = 1'b1;
						state_next = i2c_slave_pkg::S_WAIT;
						if (lines.sdaLevel)
							status_next = `ST_TX_NACK;
						else if (txLast_reg)
							status_next = `ST_TX_LAST;
						else
							status_next = `ST_TX_ACK;
						// after the last byte the data line stays released
						if (lines.sdaLevel || txLast_reg)
							state_next = i2c_slave_pkg::S_WAIT;
					end
				end
				default: state_next = i2c_slave_pkg::S_IDLE;
			endcase
		end
		// pending start goes out once the bus is free
		if (startPend_reg && lines.busFree) begin
			startPend_next = 1'b0;
			startOut_next = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_reg <= i2c_slave_pkg::S_IDLE;
			shift_reg <= 8'h00;
			bitCnt_reg <= 3'h0;
			flag_reg <= 1'b0;
			status_reg <= `ST_IDLE;
			sdaOe_reg <= 1'b0;
			sclOe_reg <= 1'b0;
			gcMode_reg <= 1'b0;
			txLast_reg <= 1'b0;
			startPend_reg <= 1'b0;
			startOut_reg <= 1'b0;
			byteDone_reg <= 1'b0;
			addrByte_reg <= 1'b0;
			statusCode <= `ST_IDLE;
		end else begin
			state_reg <= state_next;
			shift_reg <= shift_next;
			bitCnt_reg <= bitCnt_next;
			flag_reg <= flag_next;
			status_reg <= status_next;
			sdaOe_reg <= sdaOe_next;
			sclOe_reg <= sclOe_next;
			gcMode_reg <= gcMode_next;
			txLast_reg <= txLast_next;
			startPend_reg <= startPend_next;
			startOut_reg <= startOut_next;
			byteDone_reg <= byteDone_next;
			addrByte_reg <= addrByte_next;
			statusCode <= status_next;
		end
	end

	assign sclOut = 1'b0;
	assign sdaOut = 1'b0;
	assign sclOe = sclOe_reg;
	assign sdaOe = sdaOe_reg;
	assign irqFlag = flag_reg;
	assign shiftData = shift_reg;
	assign startIssued = startOut_reg;
endmodule : i2c_slave_ctrl
`default_nettype wire

// ===== verif/i2c_bus_master.sv
// behavioural bus master for the slave controller bench
// assumes open-drain lines with pull-ups; the slave gives only its enables
`timescale 1ns/1ns
`default_nettype none
module i2c_bus_master (
	// slave pin enables
	input wire logic slvSclOe,
	input wire logic slvSdaOe,
	// resolved lines and stretch timeout flag
	output logic scl,
	output logic sda,
	output logic stuck
);
	logic mScl = 1'b1;
	logic mSda = 1'b1;
	assign scl = mScl & ~slvSclOe;
	assign sda = mSda & ~slvSdaOe;
	initial stuck = 1'b0;
	// ================================================================
	// bit level, 160 ns per bit; clock stands high between frames
	task automatic rise();
		int i;
		mScl = 1'b1;
		// slave stretches while its flag is up, except on stop status A0
		for (i = 0; i < 5000 && scl !== 1'b1; i++) #10;
		if (i == 5000) stuck = 1'b1;
	endtask : rise
	task automatic start();
		mSda = 1'b1;
		rise();
		#80 mSda = 1'b0;
		#80 mScl = 1'b0;
	endtask : start
	task automatic stop();
		#40 mSda = 1'b0;
		#40 rise();
		#80 mSda = 1'b1;
		#80;
	endtask : stop
	task automatic bit_out(input logic b);
		#40 mSda = b;
		#40 rise();
		#80 mScl = 1'b0;
	endtask : bit_out
	task automatic bit_in(output logic b);
		#40 mSda = 1'b1;
		#40 rise();
		#40 b = sda;
		#40 mScl = 1'b0;
	endtask : bit_in
	// msb first, then the acknowledge bit
	task automatic wbyte(input logic [7:0] d, output logic ack);
		for (int k = 7; k >= 0; k--) bit_out(d[k]);
		bit_in(ack);
	endtask : wbyte
	task automatic rbyte(output logic [7:0] d, input logic nack);
		for (int k = 7; k >= 0; k--) bit_in(d[k]);
		bit_out(nack);
	endtask : rbyte
endmodule : i2c_bus_master
`default_nettype wire

// ===== verif/i2c_slave_ctrl_props.sv
// pin-level assertions of the slave controller
// assumes binding onto i2c_slave_ctrl, one clock domain
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_ctrl_props (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// pins and software side
	input wire logic sclOe,
	input wire logic sdaOe,
	input wire logic [7:0] ownSlaveAddr,
	input wire logic ackEnableBit,
	input wire logic startRequestBit,
	input wire logic flagClear,
	input wire logic irqFlag,
	input wire logic [7:0] statusCode,
	input wire logic startIssued
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	logic armedReg;
	logic armedNext;
	// a start is only owed after an exit state cleared with the request set
	always_comb begin
		armedNext = armedReg;
		if (irqFlag && flagClear && startRequestBit &&
			(statusCode inside {8'h98, 8'hA0, 8'hC0, 8'hC8})) armedNext = 1'b1;
		if (startIssued || reset) armedNext = 1'b0;
	end
	always_ff @(posedge clk_sys) begin
		armedReg <= armedNext;
	end
	// ================================================================
	clear_drop_a: assert property (irqFlag && flagClear |=> !irqFlag)
		else $error("flag survived its clear");
	flag_hold_a: assert property (irqFlag && !flagClear |=> irqFlag && $stable(statusCode))
		else $error("flag or status moved before clear");
	stretch_a: assert property (irqFlag && $past(irqFlag, 2) && statusCode != 8'hA0 |-> sclOe)
		else $error("clock not held while flag up");
	deaf_addr_a: assert property ($rose(irqFlag) && (statusCode inside {8'h60, 8'h70, 8'hA8}) |-> $past(ackEnableBit, 4))
		else $error("address answered with ack enable low");
	gc_enable_a: assert property ($rose(irqFlag) && statusCode == 8'h70 |-> ownSlaveAddr[0])
		else $error("general call taken while disabled");
	gc_nack_a: assert property ($rose(irqFlag) && statusCode == 8'h98 |-> !sdaOe && ownSlaveAddr[0])
		else $error("general call data status wrong");
	tx_release_a: assert property ($fell(irqFlag) && ($past(statusCode) inside {8'hC0, 8'hC8}) |-> (!sdaOe) [*8])
		else $error("data line driven after last byte");
	start_pulse_a: assert property (startIssued |=> !startIssued)
		else $error("start pulse longer than one cycle");
	start_cause_a: assert property (startIssued |-> armedReg)
		else $error("start issued without request");
	cover property ($rose(irqFlag) && statusCode == 8'hA8);
	cover property ($rose(irqFlag) && statusCode == 8'hC8);
	cover property (startIssued);
endmodule : i2c_slave_ctrl_props
bind i2c_slave_ctrl i2c_slave_ctrl_props i2c_slave_ctrl_props_inst (.clk_sys, .reset, .sclOe,
	.sdaOe, .ownSlaveAddr, .ackEnableBit, .startRequestBit, .flagClear, .irqFlag, .statusCode,
	.startIssued);
`default_nettype wire

// ===== verif/i2c_slave_rx_end_and_tx_mode_tb.sv
// self-checking bench of the slave controller against a bus master model
// assumes the checker is bound in from its own file
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_rx_end_and_tx_mode_tb;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic scl, sda, sclOe, sdaOe, irqFlag, startIssued, stuck, ackBit;
	logic ackEnableBit = 1'b0, startRequestBit = 1'b0, flagClear = 1'b0, shiftDataWrite = 1'b0;
	logic stopRequestBit = 1'b0;
	logic [7:0] ownSlaveAddr = 8'h00, shiftDataIn = 8'h00, statusCode, d, got, shiftData;
	logic [7:0] expQ[$];
	logic flagPrev = 1'b0;
	logic [6:0] adr;
	int mismatches = 0, n_checks = 0, i;
	always #5 clk_sys = ~clk_sys;
	i2c_slave_ctrl i2c_slave_ctrl_inst (.clk_sys, .reset, .sclIn(scl), .sdaIn(sda), .sclOut(),
		.sclOe, .sdaOut(), .sdaOe, .ownSlaveAddr, .ackEnableBit, .startRequestBit,
		.stopRequestBit, .flagClear, .shiftDataIn, .shiftDataWrite, .irqFlag,
		.statusCode, .shiftData, .startIssued);
	i2c_bus_master i2c_bus_master_inst (.slvSclOe(sclOe), .slvSdaOe(sdaOe), .scl, .sda, .stuck);
	// ================================================================
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// software side: bits and data first, clear afterwards
	task automatic sw(input logic ack, input logic start_request_bit, input logic ld, input logic [7:0] dat);
		int k;
		for (k = 0; k < 3000 && irqFlag !== 1'b1; k++) @(negedge clk_sys);
		if (k == 3000) begin
			mismatches++;
			wrap_up();
		end
		ackEnableBit = ack;
		startRequestBit = start_request_bit;
		shiftDataIn = dat;
		shiftDataWrite = ld;
		@(negedge clk_sys);
		shiftDataWrite = 1'b0;
		flagClear = 1'b1;
		@(negedge clk_sys);
		flagClear = 1'b0;
	endtask : sw
	task automatic addr(input logic [7:0] b, input logic nackExp);
		i2c_bus_master_inst.start();
		i2c_bus_master_inst.wbyte(b, ackBit);
		chk("address ack", {7'h00, nackExp}, {7'h00, ackBit});
	endtask : addr
	task automatic rd(input logic nack, input logic [7:0] exp);
		i2c_bus_master_inst.rbyte(got, nack);
		chk("read data", exp, got);
	endtask : rd
	// ================================================================
	// status watcher: every new flag takes the oldest expectation
	always @(negedge clk_sys) begin
		flagPrev <= irqFlag;
		if (irqFlag === 1'b1 && flagPrev !== 1'b1) begin
			if (expQ.size() == 0) chk("unexpected flag", 8'hF8, statusCode);
			else chk("status", expQ.pop_front(), statusCode);
		end
	end
	always @(posedge stuck) begin
		mismatches++;
		wrap_up();
	end
	initial begin
		void'($urandom(32'h92134FCB));
		adr = 7'h10 + 7'($urandom % 96);
		repeat (8) @(negedge clk_sys);
		reset = 1'b0;
		ownSlaveAddr = {adr, 1'b0};
		addr({adr, 1'b0}, 1'b1);
		i2c_bus_master_inst.stop();
		@(negedge clk_sys);
		ackEnableBit = 1'b1;
		addr(8'h00, 1'b1);
		i2c_bus_master_inst.stop();
		expQ.push_back(8'h60);
		addr({adr, 1'b0}, 1'b0);
		sw(1'b1, 1'b0, 1'b0, 8'h00);
		expQ.push_back(8'hA0);
		i2c_bus_master_inst.stop();
		sw(1'b1, 1'b0, 1'b0, 8'h00);
		$display("test isolation and stop done");
		expQ.push_back(8'hA8);
		addr({adr, 1'b1}, 1'b0);
		d = 8'($urandom);
		expQ.push_back(8'hB8);
		sw(1'b1, 1'b0, 1'b1, d);
		rd(1'b0, d);
		d = 8'($urandom);
		expQ.push_back(8'hC8);
		sw(1'b0, 1'b0, 1'b1, d);
		rd(1'b0, d);
		sw(1'b1, 1'b0, 1'b0, 8'h00);
		rd(1'b1, 8'hFF);
		i2c_bus_master_inst.stop();
		expQ.push_back(8'hA8);
		addr({adr, 1'b1}, 1'b0);
		d = 8'($urandom);
		expQ.push_back(8'hC0);
		sw(1'b1, 1'b0, 1'b1, d);
		rd(1'b1, d);
		sw(1'b1, 1'b0, 1'b0, 8'h00);
		i2c_bus_master_inst.stop();
		$display("test transmitter done");
		@(negedge clk_sys);
		ownSlaveAddr = {adr, 1'b1};
		expQ.push_back(8'h70);
		addr(8'h00, 1'b0);
		sw(1'b0, 1'b0, 1'b0, 8'h00);
		expQ.push_back(8'h98);
		d = 8'($urandom);
		i2c_bus_master_inst.wbyte(d, ackBit);
		chk("general call data ack", 8'h01, {7'h00, ackBit});
		repeat (8) @(negedge clk_sys);
		chk("general call data", d, shiftData);
		sw(1'b0, 1'b1, 1'b0, 8'h00);
		i2c_bus_master_inst.stop();
		addr({adr, 1'b1}, 1'b1);
		i2c_bus_master_inst.stop();
		for (i = 0; i < 2000 && startIssued !== 1'b1; i++) @(posedge clk_sys);
		chk("start issued", 8'h01, {7'h00, startIssued});
		chk("pending flags", 8'h00, 8'(expQ.size()));
		$display("test general call and start done");
		wrap_up();
	end
endmodule : i2c_slave_rx_end_and_tx_mode_tb
`default_nettype wire
